/* File: src/dual_comparator_pkg.sv */
// Shared constants, types and carriers of the dual comparator control block
package dual_comparator_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL  = 8'h00;
	localparam logic [7:0] ADDR_FLAGS    = 8'h04;
	localparam logic [7:0] ADDR_ENABLES  = 8'h08;
	localparam logic [7:0] ADDR_PRIORITY = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CMP2_RESULT_BIT   = 7;
	localparam int CMP1_RESULT_BIT   = 6;
	localparam int CMP2_POLARITY_BIT = 5;
	localparam int CMP1_POLARITY_BIT = 4;
	localparam int INV_SELECT_BIT    = 3;
	localparam int CONFIG_MSB        = 2;
	localparam int CHANGE_BIT        = 6;
	localparam int SETTLING_BIT      = 0;

	localparam logic [7:0] CONTROL_WMASK  = 8'h3F;
	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] FLAGS_RESET    = 8'h00;
	localparam logic [7:0] ENABLES_RESET  = 8'h00;
	localparam logic [7:0] PRIORITY_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Operating configurations
	// ----------------------------------------------------------------
	localparam logic [2:0] CFG_RESET       = 3'h0;
	localparam logic [2:0] CFG_ONE_INDEP   = 3'h1;
	localparam logic [2:0] CFG_TWO_INDEP   = 3'h2;
	localparam logic [2:0] CFG_COMMON_REF  = 3'h3;
	localparam logic [2:0] CFG_COMMON_OUT  = 3'h4;
	localparam logic [2:0] CFG_INDEP_OUT   = 3'h5;
	localparam logic [2:0] CFG_MUX_VREF    = 3'h6;
	localparam logic [2:0] CFG_OFF         = 3'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 50;
	localparam int MODE_CHANGE_DELAY_NS = 10000;
	localparam int MODE_CHANGE_CYCLES  =
		(MODE_CHANGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Analog routing carrier
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_NONE, SRC_PIN1, SRC_PIN2, SRC_PIN3, SRC_PIN4, SRC_PIN5, SRC_PIN6, SRC_VREF
	} input_src_t;

	typedef struct packed {
		logic       [1:0] power_on;
		input_src_t       cmp1_pos;
		input_src_t       cmp1_neg;
		input_src_t       cmp2_pos;
		input_src_t       cmp2_neg;
		logic       [1:0] out_to_pin;
		logic       [6:1] analog_pin;
	} analog_route_t;

endpackage : dual_comparator_pkg

/* File: src/dual_comparator_control.sv */
// Dual comparator control, status and change interrupt with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps

module dual_comparator_control
	import dual_comparator_pkg::*;
#(
	parameter int MODE_DELAY_CYCLES = MODE_CHANGE_CYCLES
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic [1:0]    cmp_raw,
	input  wire logic [7:0]    port_f_direction,
	output analog_route_t      route,
	output logic [1:0]         cmp_pin_out,
	output logic [1:0]         cmp_pin_oe,
	output logic               irq
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [5:0]    control_reg;
	logic [1:0]    result_reg;
	logic [1:0]    snapshot_reg;
	logic          change_flag_reg;
	logic          change_enable_reg;
	logic          change_priority_reg;
	logic [15:0]   settle_cnt_reg;
	logic [1:0]    sync1_reg;
	logic [1:0]    sync2_reg;
	logic [1:0]    sync3_reg;
	logic [1:0]    level_reg;
	analog_route_t route_next;
	logic [1:0]    pin_out_next;

	logic          wr_fire;
	logic          rd_fire;
	logic          control_access;
	logic          flag_clear;
	logic [7:0]    wr_byte;
	logic [31:0]   rdata_next;
	logic          rd_mapped;
	logic          wr_mapped;

	logic [2:0]    cfg;
	logic          inv_select;
	logic [1:0]    polarity;

	assign cfg        = control_reg[CONFIG_MSB:0];
	assign inv_select = control_reg[INV_SELECT_BIT];
	assign polarity   = {control_reg[CMP2_POLARITY_BIT], control_reg[CMP1_POLARITY_BIT]};

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Address and data are accepted together once both are offered.
	assign wr_fire = s_axi_awvalid && s_axi_awready;
	assign wr_byte = s_axi_wdata[7:0];

	always_comb begin
		case (s_axi_awaddr)
			ADDR_CONTROL, ADDR_FLAGS, ADDR_ENABLES, ADDR_PRIORITY, ADDR_STATUS: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rdata_next = 32'h0000_0000;
		rd_mapped  = 1'b1;
		case (s_axi_araddr)
			ADDR_CONTROL:  rdata_next[7:0] = {result_reg, control_reg};
			ADDR_FLAGS:    rdata_next[CHANGE_BIT] = change_flag_reg;
			ADDR_ENABLES:  rdata_next[CHANGE_BIT] = change_enable_reg;
			ADDR_PRIORITY: rdata_next[CHANGE_BIT] = change_priority_reg;
			ADDR_STATUS:   rdata_next[SETTLING_BIT] = (settle_cnt_reg != 16'h0000);
			default:       rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdata_next;
			s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Either kind of access to the control register re-arms change detection
	assign control_access = (rd_fire && s_axi_araddr == ADDR_CONTROL)
		|| (wr_fire && s_axi_awaddr == ADDR_CONTROL);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_reg <= CONTROL_RESET[5:0];
		end else if (wr_fire && s_axi_awaddr == ADDR_CONTROL && s_axi_wstrb[0]) begin
			control_reg <= wr_byte[5:0] & CONTROL_WMASK[5:0];
		end
	end

	// Mode-change delay: results are not trusted until it runs out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_cnt_reg <= 16'h0000;
		end else if (wr_fire && s_axi_awaddr == ADDR_CONTROL && s_axi_wstrb[0]
			&& wr_byte[CONFIG_MSB:0] != cfg) begin
			settle_cnt_reg <= 16'(MODE_DELAY_CYCLES);
		end else if (settle_cnt_reg != 16'h0000) begin
			settle_cnt_reg <= settle_cnt_reg - 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Result synchronisers
	// ----------------------------------------------------------------
	// Raw comparator levels are asynchronous; a change counts only once
	// the second and third stages agree, which also rejects one-cycle glitches.
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cmp
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					sync3_reg[g] <= 1'b0;
					level_reg[g] <= 1'b0;
				end else begin
					sync1_reg[g] <= cmp_raw[g] && route_next.power_on[g];
					sync2_reg[g] <= sync1_reg[g];
					sync3_reg[g] <= sync2_reg[g];
					if (sync2_reg[g] == sync3_reg[g]) begin
						level_reg[g] <= sync3_reg[g];
					end
				end
			end

			always_comb begin
				pin_out_next[g] = level_reg[g] ^ polarity[g];
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_reg <= 2'h0;
		end else begin
			result_reg <= level_reg ^ polarity;
		end
	end

	// ----------------------------------------------------------------
	// Change detection and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			snapshot_reg <= 2'h0;
		end else if (control_access) begin
			snapshot_reg <= result_reg;
		end
	end

	assign flag_clear = wr_fire && s_axi_awaddr == ADDR_FLAGS && s_axi_wstrb[0]
		&& wr_byte[CHANGE_BIT];

	// A pending mismatch outranks a clear, so no change is ever lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			change_flag_reg <= FLAGS_RESET[CHANGE_BIT];
		end else if (result_reg != snapshot_reg) begin
			change_flag_reg <= 1'b1;
		end else if (flag_clear) begin
			change_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			change_enable_reg <= ENABLES_RESET[CHANGE_BIT];
		end else if (wr_fire && s_axi_awaddr == ADDR_ENABLES && s_axi_wstrb[0]) begin
			change_enable_reg <= wr_byte[CHANGE_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			change_priority_reg <= PRIORITY_RESET[CHANGE_BIT];
		end else if (wr_fire && s_axi_awaddr == ADDR_PRIORITY && s_axi_wstrb[0]) begin
			change_priority_reg <= wr_byte[CHANGE_BIT];
		end
	end

	// Flag sets regardless of enable; only the output is gated
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= change_flag_reg && change_enable_reg;
		end
	end

	// ----------------------------------------------------------------
	// Configuration decode
	// ----------------------------------------------------------------
	always_comb begin
		route_next            = '0;
		route_next.cmp1_pos   = SRC_NONE;
		route_next.cmp1_neg   = SRC_NONE;
		route_next.cmp2_pos   = SRC_NONE;
		route_next.cmp2_neg   = SRC_NONE;
		case (cfg)
			CFG_RESET: begin
				route_next.analog_pin = 6'h3F;
			end
			CFG_ONE_INDEP: begin
				route_next.power_on   = 2'h1;
				route_next.cmp1_neg   = SRC_PIN6;
				route_next.cmp1_pos   = SRC_PIN5;
				route_next.analog_pin = 6'h30;
			end
			CFG_TWO_INDEP, CFG_INDEP_OUT: begin
				route_next.power_on   = 2'h3;
				route_next.cmp1_neg   = SRC_PIN6;
				route_next.cmp1_pos   = SRC_PIN5;
				route_next.cmp2_neg   = SRC_PIN4;
				route_next.cmp2_pos   = SRC_PIN3;
				route_next.analog_pin = 6'h3C;
				route_next.out_to_pin = (cfg == CFG_INDEP_OUT) ? 2'h3 : 2'h0;
			end
			CFG_COMMON_REF, CFG_COMMON_OUT: begin
				route_next.power_on   = 2'h3;
				route_next.cmp1_neg   = SRC_PIN6;
				route_next.cmp1_pos   = SRC_PIN5;
				route_next.cmp2_neg   = SRC_PIN4;
				route_next.cmp2_pos   = SRC_PIN5;
				route_next.analog_pin = 6'h38;
				route_next.out_to_pin = (cfg == CFG_COMMON_OUT) ? 2'h3 : 2'h0;
			end
			CFG_MUX_VREF: begin
				route_next.power_on   = 2'h3;
				route_next.cmp1_pos   = SRC_VREF;
				route_next.cmp2_pos   = SRC_VREF;
				route_next.cmp1_neg   = inv_select ? SRC_PIN5 : SRC_PIN6;
				route_next.cmp2_neg   = inv_select ? SRC_PIN3 : SRC_PIN4;
				route_next.analog_pin = 6'h3C;
			end
			CFG_OFF: begin
				route_next.power_on   = 2'h0;
			end
			default: begin
				route_next.power_on   = 2'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Analog routing and output pins
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			route <= '{power_on: 2'h0, cmp1_pos: SRC_NONE, cmp1_neg: SRC_NONE,
				cmp2_pos: SRC_NONE, cmp2_neg: SRC_NONE, out_to_pin: 2'h0,
				analog_pin: 6'h3F};
		end else begin
			route <= route_next;
		end
	end

	// Pin 1 carries comparator 1, pin 2 comparator 2; direction bit still gates drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_pin_out <= 2'h0;
			cmp_pin_oe  <= 2'h0;
		end else begin
			cmp_pin_out <= pin_out_next;
			cmp_pin_oe  <= route_next.out_to_pin & ~port_f_direction[2:1];
		end
	end

endmodule : dual_comparator_control

/* File: sim/dual_comparator_control_monitor.sv */
// Port-level checks for the dual comparator control block
`timescale 1ns/100ps

module dual_comparator_control_monitor
	import dual_comparator_pkg::*;
#(
	parameter int MODE_DELAY_CYCLES = 16
) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [7:0]    port_f_direction,
	input wire analog_route_t route,
	input wire logic [1:0]    cmp_pin_oe,
	input wire logic          irq
);
	// ----
	// Properties
	// ----
	// The first edge has no earlier reset value to look back at
	logic armed = 1'b0;
	always @(posedge aclk) begin
		armed <= 1'b1;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_wr;
		s_axi_awready |-> s_axi_wready ##1 (!s_axi_awready && s_axi_bvalid);
	endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	property p_rd;
		s_axi_arready |=> !s_axi_arready && s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer wrong");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_oe;
		(cmp_pin_oe & $past(port_f_direction[2:1])) == 2'h0;
	endproperty
	a_oe: assert property (p_oe) else $error("pin driven while input");
	property p_vref;
		route.cmp1_pos == SRC_VREF |-> route.cmp2_pos == SRC_VREF
			&& route.cmp1_neg inside {SRC_PIN5, SRC_PIN6} && route.cmp2_neg inside {SRC_PIN3, SRC_PIN4};
	endproperty
	a_vref: assert property (p_vref) else $error("reference mode routing");
	property p_irq_fall;
		$fell(irq) |-> $past(s_axi_awready, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
	// Own disable: this one looks at the reset itself
	property p_reset;
		disable iff (1'b0) armed && !$past(aresetn) |-> route.analog_pin == 6'h3F && !irq
			&& route.power_on == 2'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : dual_comparator_control_monitor

bind dual_comparator_control dual_comparator_control_monitor #(
	.MODE_DELAY_CYCLES(MODE_DELAY_CYCLES)
) u_mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.port_f_direction(port_f_direction), .route(route), .cmp_pin_oe(cmp_pin_oe), .irq(irq)
);

/* File: sim/analog_source_model.sv */
// Analog pins and reference feeding the two comparators
`timescale 1ns/100ps

module analog_source_model
	import dual_comparator_pkg::*;
(
	input  wire analog_route_t route,
	input  wire logic [7:0]    lvl [8],
	output logic [1:0]         cmp_raw
);
	// Index 0 holds zero so an unrouted input never wins; powered-off comparator reads low
	always_comb begin
		cmp_raw[0] = route.power_on[0] && (lvl[route.cmp1_pos] > lvl[route.cmp1_neg]);
		cmp_raw[1] = route.power_on[1] && (lvl[route.cmp2_pos] > lvl[route.cmp2_neg]);
	end
endmodule : analog_source_model

/* File: sim/tb_dual_comparator_control.sv */
// Self-checking testbench of the dual comparator control block
`timescale 1ns/100ps

module tb_dual_comparator_control
	import dual_comparator_pkg::*;
;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic awr, wr_rdy, bvalid, arr, rvalid, irq;
	logic [7:0] awaddr = 0, araddr = 0, dir = 8'hFF;
	logic [31:0] wdata = 0, rdata, rdat;
	logic [1:0] bresp, rresp, rsp, raw, oe, pout;
	logic [7:0] lvl [8] = '{8'h00, 8'h00, 8'h00, 8'h32, 8'h64, 8'hC8, 8'h64, 8'h96};
	analog_route_t route;
	int miscompares = 0, checks = 0;

	always #25 aclk = ~aclk;

	dual_comparator_control #(.MODE_DELAY_CYCLES(16)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cmp_raw(raw), .port_f_direction(dir), .route(route),
		.cmp_pin_out(pout), .cmp_pin_oe(oe), .irq(irq));
	analog_source_model u_src (.route(route), .lvl(lvl), .cmp_raw(raw));

	// ----
	// Bus and compare helpers
	// ----
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int lag = 0);
		int n = 0;
		bit aw_up = 1'b1;
		bit w_up = 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= (lag == 0);
		// Each channel lets go only when its own ready is seen
		do begin
			@(posedge aclk);
			n++;
			if (awr === 1'b1) begin
				awv <= 1'b0;
				aw_up = 1'b0;
			end
			if (wr_rdy === 1'b1) begin
				wv <= 1'b0;
				w_up = 1'b0;
			end
		end while ((aw_up || w_up) && n < 50);
		repeat (lag) @(posedge aclk);
		bready <= 1'b1;
		do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		rsp = bresp;
		// Idle edge so the next call never re-raises ready in this step
		@(posedge aclk);
		if (n >= 50) begin miscompares++; summarize(); end
	endtask : wr
	task automatic rd(input logic [7:0] a, input int lag = 0);
		int n = 0;
		araddr <= a;
		arv <= 1'b1;
		rready <= (lag == 0);
		do begin @(posedge aclk); n++; end while (arr !== 1'b1 && n < 50);
		arv <= 1'b0;
		repeat (lag) @(posedge aclk);
		rready <= 1'b1;
		do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		rdat = rdata;
		rsp = rresp;
		@(posedge aclk);
		if (n >= 50) begin miscompares++; summarize(); end
	endtask : rd
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(nm, rdat, {24'h0, e});
	endtask : rchk
	task automatic settle();
		repeat (30) @(posedge aclk);
	endtask : settle

	// ----
	// Scenarios
	// ----
	task automatic test_reset();
		rchk("control", ADDR_CONTROL, 8'h00);
		rchk("flags", ADDR_FLAGS, 8'h00);
		rchk("enables", ADDR_ENABLES, 8'h00);
		rchk("priority", ADDR_PRIORITY, 8'h00);
		wr(ADDR_PRIORITY, 8'h40);
		rchk("priority rw", ADDR_PRIORITY, 8'h40);
		// Late ready: answers must stand until taken
		wr(ADDR_PRIORITY, 8'h00, 3);
		chk("late write resp", rsp, RESP_OKAY);
		rd(ADDR_PRIORITY, 3);
		chk("late read", rdat, 32'h0);
		$display("test reset done");
	endtask : test_reset
	task automatic test_results();
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_CONTROL, {2'h0, p[1:0], 4'h2});
			settle();
			rchk("results", ADDR_CONTROL, {p[1], ~p[0], p[1:0], 4'h2});
		end
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CONTROL, {4'h0, s[0], 3'h6});
			settle();
			rchk("reference mode", ADDR_CONTROL, {1'b1, ~s[0], 2'h0, s[0], 3'h6});
		end
		wr(ADDR_CONTROL, {5'h00, CFG_ONE_INDEP});
		settle();
		rchk("one comparator", ADDR_CONTROL, 8'h41);
		wr(ADDR_CONTROL, {5'h00, CFG_COMMON_REF});
		settle();
		rchk("common reference", ADDR_CONTROL, 8'hC3);
		wr(ADDR_CONTROL, 8'hF7);
		settle();
		rchk("off mode", ADDR_CONTROL, 8'hF7);
		chk("power", route.power_on, 2'h0);
		$display("test results done");
	endtask : test_results
	task automatic test_flag();
		wr(ADDR_CONTROL, 8'h02);
		rd(ADDR_STATUS);
		chk("settling", rdat, 32'h1);
		settle();
		rchk("settled", ADDR_STATUS, 8'h00);
		rd(ADDR_CONTROL);
		wr(ADDR_FLAGS, 8'h40);
		rchk("flag clear", ADDR_FLAGS, 8'h00);
		lvl[5] <= 8'h00;
		settle();
		rchk("flag masked", ADDR_FLAGS, 8'h40);
		wr(ADDR_FLAGS, 8'h40);
		rchk("mismatch", ADDR_FLAGS, 8'h40);
		rd(ADDR_CONTROL);
		wr(ADDR_FLAGS, 8'h40);
		rchk("flag ended", ADDR_FLAGS, 8'h00);
		wr(ADDR_ENABLES, 8'h40);
		lvl[5] <= 8'hC8;
		settle();
		chk("irq", irq, 1'b1);
		wr(ADDR_ENABLES, 8'h00);
		repeat (2) @(posedge aclk);
		chk("irq masked", irq, 1'b0);
		$display("test flag done");
	endtask : test_flag
	task automatic test_pins();
		wr(ADDR_CONTROL, 8'h05);
		dir <= 8'h00;
		settle();
		chk("pin enable", oe, 2'h3);
		chk("pin value", pout, 2'h1);
		dir <= 8'hFF;
		repeat (3) @(posedge aclk);
		chk("pin input", oe, 2'h0);
		dir <= 8'h00;
		wr(ADDR_CONTROL, 8'h04);
		settle();
		chk("common out", pout, 2'h3);
		chk("common drive", oe, 2'h3);
		wr(ADDR_CONTROL, 8'h00);
		settle();
		chk("reset mode pins", route.analog_pin, 6'h3F);
		rchk("reset mode result", ADDR_CONTROL, 8'h00);
		rd(8'h14);
		chk("unmapped resp", rsp, RESP_SLVERR);
		chk("unmapped data", rdat, 32'h0);
		wr(8'h14, 8'hFF);
		chk("unmapped write", rsp, RESP_SLVERR);
		$display("test pins done");
	endtask : test_pins

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_reset();
		test_results();
		test_flag();
		test_pins();
		summarize();
	end
endmodule : tb_dual_comparator_control
